// ===== hw/ccsbu_cmp_flags.sv
// Subtract-compare flag generator for the compare-with-immediate operation
`timescale 1ns/1ps
`default_nettype none
`include "ccsbu_defs.svh"

module ccsbu_cmp_flags
	import ccsbu_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Operands
	input  wire logic [WIDTH-1:0] minuend,
	input  wire logic [WIDTH-1:0] subtrahend,
	// Flags before and after
	input  wire logic [7:0]       flagsIn,
	output logic      [7:0]       flagsOut
);

	initial begin
		if (WIDTH < 5) $error("ccsbu_cmp_flags: WIDTH must be at least 5");
	end

	logic [WIDTH-1:0] diff;
	logic             borrowOut;
	logic             halfBorrow;
	logic             ovf;
	logic             neg;

	// Difference is computed but never stored; only flags leave
	assign {borrowOut, diff} = {1'b0, minuend} - {1'b0, subtrahend};
	assign halfBorrow = ({1'b0, minuend[3:0]} < {1'b0, subtrahend[3:0]});
	assign ovf = (minuend[WIDTH-1] & ~subtrahend[WIDTH-1] & ~diff[WIDTH-1])
		| (~minuend[WIDTH-1] & subtrahend[WIDTH-1] & diff[WIDTH-1]);
	assign neg = diff[WIDTH-1];

	// Only Z, N, V, C, H change; sign and the upper flags pass through untouched
	always_comb begin
		flagsOut = flagsIn;
		flagsOut[`CCSBU_FLAG_C] = borrowOut;
		flagsOut[`CCSBU_FLAG_Z] = (diff == '0);
		flagsOut[`CCSBU_FLAG_N] = neg;
		flagsOut[`CCSBU_FLAG_V] = ovf;
		flagsOut[`CCSBU_FLAG_H] = halfBorrow;
	end

endmodule : ccsbu_cmp_flags
`default_nettype wire

// ===== hw/ccsbu_unit.sv
// Compare, skip and branch execution unit of the processor core
`timescale 1ns/1ps
`default_nettype none
`include "ccsbu_defs.svh"

module ccsbu_unit
	import ccsbu_pkg::*;
#(
	parameter int PC_WIDTH  = 16,
	parameter int OFS_WIDTH = 7
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Decoded request from the decoder
	input  wire logic                 opValid,
	input  wire ccsbu_op_type         opCode,
	input  wire logic [PC_WIDTH-1:0]  pcCurrent,
	input  wire logic [2:0]           bitIndex,
	input  wire logic signed [OFS_WIDTH-1:0] branchOffset,
	input  wire logic                 nextIsTwoWord,
	// Operands from register file, immediate, I/O space, pointer pair and status flags
	input  wire logic [7:0]           destinationRegister,
	input  wire logic [7:0]           sourceRegister,
	input  wire logic [7:0]           immediateValue,
	input  wire logic [7:0]           ioRegister,
	input  wire logic [PC_WIDTH-1:0]  pointerPair,
	input  wire logic [7:0]           statusFlagsRegister,
	// Results
	output logic                      pcLoad,
	output logic [PC_WIDTH-1:0]       pcNext,
	output logic                      flagsLoad,
	output logic [7:0]                flagsNext,
	output logic                      skipTaken
);

	initial begin
		if (PC_WIDTH < 2 || PC_WIDTH > 16) $error("ccsbu_unit: PC_WIDTH out of range");
		if (OFS_WIDTH < 2 || OFS_WIDTH >= PC_WIDTH) $error("ccsbu_unit: OFS_WIDTH out of range");
	end

	// Sign-extended relative target, used by both branch kinds
	function automatic logic [PC_WIDTH-1:0] relTarget(input logic [PC_WIDTH-1:0] pc,
		input logic signed [OFS_WIDTH-1:0] ofs);
		logic [PC_WIDTH-1:0] ext;
		ext = PC_WIDTH'(signed'(ofs));
		relTarget = pc + ext + PC_WIDTH'(`CCSBU_STEP_NEXT);
	endfunction : relTarget

	// Bit pick shared by all bit tests
	function automatic logic pickBit(input logic [7:0] val, input logic [2:0] idx);
		pickBit = val[idx];
	endfunction : pickBit

	// Decoded conditions
	wire logic        isCall     = opValid && (opCode == OP_INDIRECT_CALL_IND);
	wire logic        isCmpSkip  = opValid && (opCode == OP_CMP_SKIP_EQ);
	wire logic        isCmpImm   = opValid && (opCode == OP_CMP_IMM);
	wire logic        isSkipRb   = opValid && (opCode == OP_SKIP_RB_CLR);
	wire logic        isSkipIoC  = opValid && (opCode == OP_SKIP_IO_CLR);
	wire logic        isSkipIoS  = opValid && (opCode == OP_SKIP_IO_SET);
	wire logic        isBrSet    = opValid && (opCode == OP_BR_FLAG_SET);
	wire logic        isBrClr    = opValid && (opCode == OP_BR_FLAG_CLR);
	wire logic        flagBit    = pickBit(statusFlagsRegister, bitIndex);

	wire logic        skipEq     = isCmpSkip && (destinationRegister == sourceRegister);
	wire logic        skipRb     = isSkipRb && !pickBit(sourceRegister, bitIndex);
	wire logic        skipIoC    = isSkipIoC && !pickBit(ioRegister, bitIndex);
	wire logic        skipIoS    = isSkipIoS && pickBit(ioRegister, bitIndex);
	wire logic        anySkip    = skipEq | skipRb | skipIoC | skipIoS;
	wire logic        brTaken    = (isBrSet && flagBit) || (isBrClr && !flagBit);

	// Skip distance: 2 over a one-word follower, 3 over a two-word one
	wire logic [PC_WIDTH-1:0] skipStep = nextIsTwoWord ?
		PC_WIDTH'(`CCSBU_STEP_SKIP2) : PC_WIDTH'(`CCSBU_STEP_SKIP1);

	wire logic [7:0] cmpFlags;

	// Flag arithmetic lives apart so the subtractor can be reused
	ccsbu_cmp_flags #(
		.WIDTH (8)
	) u_cmp (
		.minuend    (destinationRegister),
		.subtrahend (immediateValue),
		.flagsIn    (statusFlagsRegister),
		.flagsOut   (cmpFlags)
	);

	// Next program counter: fall-through unless a case redirects it
	logic [PC_WIDTH-1:0] pcSel;
	always_comb begin
		pcSel = pcCurrent + PC_WIDTH'(`CCSBU_STEP_NEXT);
		if (isCall)
			pcSel = pointerPair;
		else if (anySkip)
			pcSel = pcCurrent + skipStep;
		else if (brTaken)
			pcSel = relTarget(pcCurrent, branchOffset);
	end

	logic                pcLoad_r;
	logic [PC_WIDTH-1:0] pcNext_r;
	logic                flagsLoad_r;
	logic [7:0]          flagsNext_r;
	logic                skipTaken_r;

	// Result registers; one cycle after the request is taken
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pcLoad_r    <= 1'b0;
			pcNext_r    <= PC_WIDTH'(`CCSBU_PC_RESET);
			flagsLoad_r <= 1'b0;
			flagsNext_r <= `CCSBU_FLAGS_RESET;
			skipTaken_r <= 1'b0;
		end else begin
			pcLoad_r    <= opValid && (opCode != OP_CMP_IMM) && (opCode != OP_NONE);
			pcNext_r    <= pcSel;
			flagsLoad_r <= isCmpImm; // only this op writes flags
			flagsNext_r <= isCmpImm ? cmpFlags : statusFlagsRegister;
			skipTaken_r <= anySkip;
		end
	end

	assign pcLoad    = pcLoad_r;
	assign pcNext    = pcNext_r;
	assign flagsLoad = flagsLoad_r;
	assign flagsNext = flagsNext_r;
	assign skipTaken = skipTaken_r;

endmodule : ccsbu_unit
`default_nettype wire

// ===== inc/ccsbu_defs.svh
// Constants for the compare, skip and branch unit
`ifndef CCSBU_DEFS_SVH
`define CCSBU_DEFS_SVH

// Status flag bit positions
`define CCSBU_FLAG_C 0
`define CCSBU_FLAG_Z 1
`define CCSBU_FLAG_N 2
`define CCSBU_FLAG_V 3
`define CCSBU_FLAG_S 4
`define CCSBU_FLAG_H 5

// Program counter steps in words
`define CCSBU_STEP_NEXT 16'h0001
`define CCSBU_STEP_SKIP1 16'h0002
`define CCSBU_STEP_SKIP2 16'h0003

// Reset value of the result registers
`define CCSBU_PC_RESET 16'h0000
`define CCSBU_FLAGS_RESET 8'h00

`endif

// ===== inc/ccsbu_pkg.sv
// Types for the compare, skip and branch unit
package ccsbu_pkg;

	// Operation selected by the decoder, one-hot except OP_NONE, which is all zero
	typedef enum logic [7:0] {
		OP_NONE        = 8'h00,
		OP_INDIRECT_CALL_IND   = 8'h01,
		OP_CMP_SKIP_EQ = 8'h02,
		OP_CMP_IMM     = 8'h04,
		OP_SKIP_RB_CLR = 8'h08,
		OP_SKIP_IO_CLR = 8'h10,
		OP_SKIP_IO_SET = 8'h20,
		OP_BR_FLAG_SET = 8'h40,
		OP_BR_FLAG_CLR = 8'h80
	} ccsbu_op_type;

endpackage : ccsbu_pkg

// ===== testbench/ccsbu_core_model.sv
// Core-side model: status flags register and one I/O register
`timescale 1ns/1ps
`default_nettype none
module ccsbu_core_model #(parameter logic [7:0] IO_VAL = 8'ha5) (
	// Clock, reset and flag update
	input wire logic       mclk, rst_n, flagsLoad,
	input wire logic [7:0] flagsNext,
	// Operands back to the unit
	output logic [7:0]     ioRegister, statusFlagsRegister
);
	// Flags hold until the unit asks for an update
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) statusFlagsRegister <= 8'h00;
		else if (flagsLoad) statusFlagsRegister <= flagsNext;
	end
	// Mixed pattern, so both levels occur across the bit indices
	assign ioRegister = IO_VAL;
endmodule : ccsbu_core_model
`default_nettype wire

// ===== testbench/ccsbu_monitor.sv
// Port checker of the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module ccsbu_monitor
	import ccsbu_pkg::*;
(
	// Request
	input wire logic              mclk, rst_n, opValid, nextIsTwoWord,
	input var  ccsbu_op_type      opCode,
	input wire logic [15:0]       pcCurrent, pointerPair, pcNext,
	input wire logic [2:0]        bitIndex,
	input wire logic signed [6:0] branchOffset,
	// Operands and results
	input wire logic [7:0]        destinationRegister, sourceRegister, ioRegister,
	input wire logic [7:0]        statusFlagsRegister, flagsNext,
	input wire logic              pcLoad, flagsLoad, skipTaken
);
	// Branch target, offset sign extended before the add
	wire logic [15:0] tgt = pcCurrent + 16'(branchOffset) + 16'h0001;
	wire logic        v   = opValid;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_CALL: assert property (v && opCode == OP_INDIRECT_CALL_IND
		|=> pcLoad && !flagsLoad && pcNext == $past(pointerPair)) else $error("call");
	AST_COMPARE_SKIP_EQUAL: assert property (
		v && opCode == OP_CMP_SKIP_EQ && destinationRegister == sourceRegister
		|=> skipTaken && !flagsLoad) else $error("compare_skip_equal");
	AST_CPI: assert property (v && opCode == OP_CMP_IMM |=> flagsLoad && !pcLoad
		&& flagsNext[7:6] == $past(statusFlagsRegister[7:6])
		&& flagsNext[4] == $past(statusFlagsRegister[4])) else $error("cpi");
	AST_IDLE: assert property (!v |=> !pcLoad && !flagsLoad && !skipTaken)
		else $error("idle");
	AST_RBC: assert property (v && opCode == OP_SKIP_RB_CLR
		&& !sourceRegister[bitIndex] |=> skipTaken) else $error("rbc");
	AST_IOC: assert property (v && opCode == OP_SKIP_IO_CLR
		&& !ioRegister[bitIndex] |=> skipTaken) else $error("ioc");
	AST_IOS: assert property (v && opCode == OP_SKIP_IO_SET
		&& ioRegister[bitIndex] |=> skipTaken) else $error("ios");
	AST_BRS: assert property (v && opCode == OP_BR_FLAG_SET
		&& statusFlagsRegister[bitIndex] |=> pcLoad && pcNext == $past(tgt)) else $error("brs");
	AST_BRC: assert property (v && opCode == OP_BR_FLAG_CLR
		&& !statusFlagsRegister[bitIndex] |=> pcNext == $past(tgt)) else $error("brc");
	AST_SKIP: assert property (skipTaken |-> pcLoad && pcNext == $past(pcCurrent)
		+ ($past(nextIsTwoWord) ? 16'h0003 : 16'h0002)) else $error("skip");
endmodule : ccsbu_monitor
bind ccsbu_unit ccsbu_monitor mon_u (.*);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench of the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ccsbu_pkg::*;
;
	localparam logic [7:0] IOV = 8'ha5;
	localparam logic [7:0] FL = 8'h25;
	// Stimulus and results
	logic mclk = 1'h0, rst_n = 1'h0, opValid = 1'h0, nextIsTwoWord = 1'h0;
	logic pcLoad, flagsLoad, skipTaken;
	ccsbu_op_type opCode = OP_NONE;
	logic [15:0] pcCurrent = 16'h0100, pointerPair = 16'h1234, pcNext;
	logic [7:0] destinationRegister = 8'h00, sourceRegister = 8'h00, immediateValue = 8'h00;
	logic [7:0] ioRegister, statusFlagsRegister, flagsNext;
	logic [2:0] bitIndex = 3'h0;
	logic signed [6:0] branchOffset = -7'sh03;
	int error_cnt = 0, total_checks = 0;
	ccsbu_unit dut_u (.mclk, .rst_n, .opValid, .opCode, .pcCurrent, .bitIndex, .branchOffset,
		.nextIsTwoWord, .destinationRegister, .sourceRegister, .immediateValue, .ioRegister,
		.pointerPair, .statusFlagsRegister, .pcLoad, .pcNext, .flagsLoad, .flagsNext, .skipTaken);
	ccsbu_core_model #(.IO_VAL(IOV)) core_u (.mclk, .rst_n, .flagsLoad, .flagsNext,
		.ioRegister, .statusFlagsRegister);
	initial forever #50 mclk = ~mclk;
	task automatic chk(input logic [19:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Requests stay high, so ops run back to back
	task automatic op(input ccsbu_op_type c, input logic [2:0] b);
		opValid = 1'h1;
		opCode = c;
		bitIndex = b;
		@(negedge mclk);
	endtask : op
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic t_cmp;
		op(OP_INDIRECT_CALL_IND, 3'h0);
		chk({pcLoad, flagsLoad, pcNext}, 20'h21234);
		destinationRegister = 8'h3c;
		sourceRegister = 8'h3c;
		nextIsTwoWord = 1'h1;
		op(OP_CMP_SKIP_EQ, 3'h0);
		chk({skipTaken, flagsLoad, pcNext}, 20'h20103);
		sourceRegister = 8'h3d;
		op(OP_CMP_SKIP_EQ, 3'h0);
		chk({skipTaken, pcNext}, 20'h00101);
		immediateValue = 8'h3c;
		op(OP_CMP_IMM, 3'h0);
		chk({flagsLoad, pcLoad, flagsNext}, 20'h202);
		destinationRegister = 8'h00;
		immediateValue = 8'h01;
		op(OP_CMP_IMM, 3'h0);
		chk({flagsLoad, pcLoad, flagsNext}, 20'h200 | FL);
	endtask : t_cmp
	task automatic t_bit;
		sourceRegister = 8'ha5;
		for (int b = 0; b < 8; b++) begin
			nextIsTwoWord = b[1];
			op(OP_SKIP_RB_CLR, 3'(b));
			chk({skipTaken, pcNext}, {!IOV[b], pcCurrent + (IOV[b] ? 16'h1 : 16'h2 + nextIsTwoWord)});
			op(OP_SKIP_IO_CLR, 3'(b));
			chk({skipTaken, pcNext}, {!IOV[b], pcCurrent + (IOV[b] ? 16'h1 : 16'h2 + nextIsTwoWord)});
			op(OP_SKIP_IO_SET, 3'(b));
			chk({skipTaken, pcNext}, {IOV[b], pcCurrent + (IOV[b] ? 16'h2 + nextIsTwoWord : 16'h1)});
			op(OP_BR_FLAG_SET, 3'(b));
			chk(pcNext, FL[b] ? 16'h00fe : 16'h0101);
			op(OP_BR_FLAG_CLR, 3'(b));
			chk(pcNext, FL[b] ? 16'h0101 : 16'h00fe);
		end
	endtask : t_bit
	initial begin
		repeat (5) @(negedge mclk);
		rst_n = 1'h1;
		t_cmp;
		t_bit;
		opValid = 1'h0;
		@(negedge mclk);
		chk(pcLoad, 1'h0);
		end_sim;
	end
	// Hang guard
	initial begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		end_sim;
	end
endmodule : tb_top
`default_nettype wire
